// ---- pkg/pfs_pkg.sv ----
// pfs_pkg: register map, field positions and carriers for the port 3
// output function select block.
// assumes a 32-bit Avalon-MM slave decoding full byte addresses.
package pfs_pkg;

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [31:0] ADDR_SET   = 32'h4002_8110;
    localparam logic [31:0] ADDR_CLR   = 32'h4002_8114;
    localparam logic [31:0] ADDR_STATE = 32'h4002_8118;
    localparam logic [31:0] ADDR_ROUTE = 32'h4002_811C;

    // --------------------------------------------------------------
    // fields
    // --------------------------------------------------------------
    localparam logic [31:0] SEL_MASK   = 32'h0005_B404;
    localparam logic [31:0] SEL_RESET  = 32'h0000_0000;
    localparam logic [31:0] RSVD_MASK  = ~SEL_MASK;
    localparam int          BIT_P18    = 18;
    localparam int          BIT_P16    = 16;
    localparam int          BIT_P15    = 15;
    localparam int          BIT_P13    = 13;
    localparam int          BIT_P12    = 12;
    localparam int          BIT_P10    = 10;
    localparam int          BIT_P2     = 2;
    localparam int          MC_CLK_BIT = 6;
    localparam int          ROUTE_LCD  = 31;
    localparam int          ROUTE_MC   = 30;
    localparam int          ROUTE_RSVD = 29;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic p18;
        logic p16;
        logic p15;
        logic p13;
        logic p12;
        logic p10;
        logic p2;
    } pfs_pins_t;

    typedef struct packed {
        logic motor_pwm_ch0_out_a;
        logic motor_pwm_ch0_out_b;
        logic motor_pwm_ch1_out_a;
        logic motor_pwm_ch1_out_b;
        logic motor_pwm_ch2_out_a;
        logic motor_pwm_ch2_out_b;
    } pfs_motor_t;

    typedef struct packed {
        logic lcd_line_pulse;
        logic lcd_data_enable;
        logic lcd_ac_bias;
        logic lcd_frame_pulse;
        logic lcd_dot_clock;
        logic lcd_line_latch;
        logic lcd_panel_power;
        logic lcd_video_bit0;
    } pfs_lcd_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } pfs_bus_state_t;

    function automatic pfs_pins_t to_pins(input logic [31:0] w);
        pfs_pins_t p;
        p.p18 = w[BIT_P18];
        p.p16 = w[BIT_P16];
        p.p15 = w[BIT_P15];
        p.p13 = w[BIT_P13];
        p.p12 = w[BIT_P12];
        p.p10 = w[BIT_P10];
        p.p2  = w[BIT_P2];
        return p;
    endfunction

    function automatic logic [31:0] from_pins(input pfs_pins_t p);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[BIT_P18] = p.p18;
        w[BIT_P16] = p.p16;
        w[BIT_P15] = p.p15;
        w[BIT_P13] = p.p13;
        w[BIT_P12] = p.p12;
        w[BIT_P10] = p.p10;
        w[BIT_P2]  = p.p2;
        return w;
    endfunction

endpackage

// ---- core/pfs_pin_drive.sv ----
// pfs_pin_drive: per-pin source selection with registered pad drive.
// assumes peripheral and gpo sources are synchronous to clk_sys.
`timescale 1ns/10ps
module pfs_pin_drive
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire pfs_pkg::pfs_pins_t  alt_on,
    input  wire logic              lcd_on,
    input  wire logic              lcd_tft_mode,
    input  wire pfs_pkg::pfs_pins_t  gpo,
    input  wire pfs_pkg::pfs_motor_t motor,
    input  wire logic              timer1_match_out0,
    input  wire pfs_pkg::pfs_lcd_t   lcd,
    output      pfs_pkg::pfs_pins_t  pad_out
);

    // --------------------------------------------------------------
    // source pick
    // --------------------------------------------------------------
    // lcd first, then peripheral, else plain output
    function automatic logic pick(input logic lcd_sel, input logic lcd_sig,
                                  input logic alt_sel, input logic alt_sig,
                                  input logic gpo_sig);
        return lcd_sel ? lcd_sig : (alt_sel ? alt_sig : gpo_sig);
    endfunction

    // panel type picks which lcd signal owns pin 16
    wire logic               lcd_p16 = lcd_tft_mode ? lcd.lcd_data_enable : lcd.lcd_ac_bias;
    pfs_pkg::pfs_pins_t      pad_next;
    pfs_pkg::pfs_pins_t      pad_reg;

    assign pad_next.p18 = pick(lcd_on, lcd.lcd_line_pulse, alt_on.p18, motor.motor_pwm_ch0_out_a, gpo.p18);
    assign pad_next.p16 = pick(lcd_on, lcd_p16, alt_on.p16, motor.motor_pwm_ch0_out_b, gpo.p16);
    assign pad_next.p15 = pick(lcd_on, lcd.lcd_frame_pulse, alt_on.p15, motor.motor_pwm_ch1_out_a, gpo.p15);
    assign pad_next.p13 = pick(lcd_on, lcd.lcd_dot_clock, alt_on.p13, motor.motor_pwm_ch1_out_b, gpo.p13);
    assign pad_next.p12 = pick(lcd_on, lcd.lcd_line_latch, alt_on.p12, motor.motor_pwm_ch2_out_a, gpo.p12);
    assign pad_next.p10 = pick(lcd_on, lcd.lcd_panel_power, alt_on.p10, motor.motor_pwm_ch2_out_b, gpo.p10);
    assign pad_next.p2  = pick(lcd_on, lcd.lcd_video_bit0, alt_on.p2, timer1_match_out0, gpo.p2);

    // --------------------------------------------------------------
    // pad register
    // --------------------------------------------------------------
    // one cycle of latency traded for glitch-free pads
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_reg <= '0;
        end
        else
        begin
            pad_reg <= pad_next;
        end
    end

    assign pad_out = pad_reg;

endmodule

// ---- core/pfs_port3_mux.sv ----
// pfs_port3_mux: port 3 output function select, avalon-mm register slave
// and pin source multiplexer.
// assumes one avalon master that holds each request until waitrequest low.
`timescale 1ns/10ps
module pfs_port3_mux
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic [31:0]         avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output      logic [31:0]         avs_readdata,
    output      logic                avs_waitrequest,
    output      logic [1:0]          avs_response,
    input  wire logic [31:0]         timer_clock_control_reg,
    input  wire logic                lcd_enable,
    input  wire logic                lcd_tft_mode,
    input  wire logic                gp_output_18,
    input  wire logic                gp_output_16,
    input  wire logic                gp_output_15,
    input  wire logic                gp_output_13,
    input  wire logic                gp_output_12,
    input  wire logic                gp_output_10,
    input  wire logic                gp_output_2,
    input  wire pfs_pkg::pfs_motor_t motor_pwm,
    input  wire logic                timer1_match_out0,
    input  wire pfs_pkg::pfs_lcd_t   lcd_signals,
    output      pfs_pkg::pfs_pins_t  pad_out
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // set wins when both arrive, only used for the sticky flag
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    pfs_pkg::pfs_bus_state_t bus_state_reg;
    pfs_pkg::pfs_bus_state_t bus_state_next;
    logic [31:0]             sel_reg;
    logic [31:0]             sel_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic [1:0]              resp_reg;
    logic [1:0]              resp_next;
    logic                    rsvd_reg;
    logic                    rsvd_next;

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    wire logic        req       = avs_read | avs_write;
    wire logic        hit_set   = (avs_address == pfs_pkg::ADDR_SET);
    wire logic        hit_clr   = (avs_address == pfs_pkg::ADDR_CLR);
    wire logic        hit_state = (avs_address == pfs_pkg::ADDR_STATE);
    wire logic        hit_route = (avs_address == pfs_pkg::ADDR_ROUTE);
    wire logic        mapped    = hit_set | hit_clr | hit_state | hit_route;
    wire logic        in_answer = (bus_state_reg == pfs_pkg::BUS_ANSWER);
    wire logic        first     = req & ~in_answer;
    wire logic        commit    = req & in_answer;
    wire logic [31:0] wr_bytes  = avs_writedata & lane_mask(avs_byteenable);

    // --------------------------------------------------------------
    // write commands
    // --------------------------------------------------------------
    // reserved positions are masked off so stray ones cannot select
    wire logic        do_set    = commit & avs_write & hit_set;
    wire logic        do_clr    = commit & avs_write & hit_clr;
    wire logic [31:0] set_bits  = do_set ? (wr_bytes & pfs_pkg::SEL_MASK) : 32'h0000_0000;
    wire logic [31:0] clr_bits  = do_clr ? (wr_bytes & pfs_pkg::SEL_MASK) : 32'h0000_0000;
    wire logic        rsvd_hit  = (do_set | do_clr) & (|(wr_bytes & pfs_pkg::RSVD_MASK));
    wire logic        rsvd_ack  = commit & avs_write & hit_route & wr_bytes[pfs_pkg::ROUTE_RSVD];

    // zeros leave bits alone, a held bit changes only on a one
    assign sel_next  = (sel_reg | set_bits) & ~clr_bits;
    assign rsvd_next = sticky(rsvd_reg, rsvd_hit, rsvd_ack);

    // --------------------------------------------------------------
    // effective routing
    // --------------------------------------------------------------
    wire logic               mc_clk_on = timer_clock_control_reg[pfs_pkg::MC_CLK_BIT];
    wire pfs_pkg::pfs_pins_t sel_pins  = pfs_pkg::to_pins(sel_reg);
    pfs_pkg::pfs_pins_t      alt_on;
    pfs_pkg::pfs_pins_t      gpo_pins;

    // motor outputs need the timer clock, else the pin stays on its gpo
    assign alt_on.p18 = sel_pins.p18 & mc_clk_on;
    assign alt_on.p16 = sel_pins.p16 & mc_clk_on;
    assign alt_on.p15 = sel_pins.p15 & mc_clk_on;
    assign alt_on.p13 = sel_pins.p13 & mc_clk_on;
    assign alt_on.p12 = sel_pins.p12 & mc_clk_on;
    assign alt_on.p10 = sel_pins.p10 & mc_clk_on;
    assign alt_on.p2  = sel_pins.p2;

    assign gpo_pins.p18 = gp_output_18;
    assign gpo_pins.p16 = gp_output_16;
    assign gpo_pins.p15 = gp_output_15;
    assign gpo_pins.p13 = gp_output_13;
    assign gpo_pins.p12 = gp_output_12;
    assign gpo_pins.p10 = gp_output_10;
    assign gpo_pins.p2  = gp_output_2;

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    logic [31:0] route_word;
    logic [31:0] rd_word;

    always_comb
    begin
        route_word = pfs_pkg::from_pins(lcd_enable ? '1 : alt_on);
        route_word[pfs_pkg::ROUTE_LCD]  = lcd_enable;
        route_word[pfs_pkg::ROUTE_MC]   = mc_clk_on;
        route_word[pfs_pkg::ROUTE_RSVD] = rsvd_reg;
    end

    // state shows the stored selection, not the overridden one
    assign rd_word = hit_state ? (sel_reg & pfs_pkg::SEL_MASK) :
                     hit_route ? route_word :
                     32'h0000_0000;

    assign rdata_next = (first & avs_read) ? rd_word : rdata_reg;
    assign resp_next  = first ? (mapped ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR) : resp_reg;

    // --------------------------------------------------------------
    // bus sequencer
    // --------------------------------------------------------------
    // every access takes two edges: capture, then answer
    always_comb
    begin
        bus_state_next = bus_state_reg;
        unique case (bus_state_reg)
            pfs_pkg::BUS_IDLE:
            begin
                if (req)
                begin
                    bus_state_next = pfs_pkg::BUS_ANSWER;
                end
            end
            pfs_pkg::BUS_ANSWER:
            begin
                bus_state_next = pfs_pkg::BUS_IDLE;
            end
        endcase
    end

    assign avs_waitrequest = req & ~in_answer;
    assign avs_readdata    = rdata_reg;
    assign avs_response    = resp_reg;

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_state_reg <= pfs_pkg::BUS_IDLE;
            rdata_reg     <= 32'h0000_0000;
            resp_reg      <= pfs_pkg::RESP_OKAY;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
            rdata_reg     <= rdata_next;
            resp_reg      <= resp_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg  <= pfs_pkg::SEL_RESET;
            rsvd_reg <= 1'b0;
        end
        else
        begin
            sel_reg  <= sel_next;
            rsvd_reg <= rsvd_next;
        end
    end

    // --------------------------------------------------------------
    // pin drive
    // --------------------------------------------------------------
    pfs_pin_drive u_drive
    (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .alt_on            (alt_on),
        .lcd_on            (lcd_enable),
        .lcd_tft_mode      (lcd_tft_mode),
        .gpo               (gpo_pins),
        .motor             (motor_pwm),
        .timer1_match_out0 (timer1_match_out0),
        .lcd               (lcd_signals),
        .pad_out           (pad_out)
    );

endmodule

// ---- dv/pfs_port3_mux_asserts.sv ----
// checker for pfs_port3_mux: bus wait timing, a shadow of the selection, pad source pick.
// assumes it is bound to pfs_port3_mux and sees only that module's ports, one clock domain.
`timescale 1ns/10ps
module pfs_port3_mux_asserts
(
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic [31:0]         avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [1:0]          avs_response,
    input wire logic [31:0]         timer_clock_control_reg,
    input wire logic                lcd_enable,
    input wire logic                lcd_tft_mode,
    input wire logic                gp_output_18,
    input wire logic                gp_output_2,
    input wire pfs_pkg::pfs_motor_t motor_pwm,
    input wire logic                timer1_match_out0,
    input wire pfs_pkg::pfs_lcd_t   lcd_signals,
    input wire pfs_pkg::pfs_pins_t  pad_out
);
    // ----------------------------------------------------------------
    // shadow of the selection
    // ----------------------------------------------------------------
    logic [31:0] lane_mask;
    logic [31:0] hit_bits;
    logic        commit_wr;
    logic        commit_any;
    logic        mapped;
    logic [31:0] sel_reg;
    logic [6:0]  lcd_pick;

    assign lane_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign hit_bits   = avs_writedata & lane_mask & pfs_pkg::SEL_MASK;
    assign commit_wr  = avs_write && !avs_waitrequest;
    assign commit_any = (avs_read || avs_write) && !avs_waitrequest;
    assign mapped     = avs_address == pfs_pkg::ADDR_SET || avs_address == pfs_pkg::ADDR_CLR
                     || avs_address == pfs_pkg::ADDR_STATE || avs_address == pfs_pkg::ADDR_ROUTE;
    assign lcd_pick   = {lcd_signals.lcd_line_pulse,
                         lcd_tft_mode ? lcd_signals.lcd_data_enable : lcd_signals.lcd_ac_bias,
                         lcd_signals.lcd_frame_pulse, lcd_signals.lcd_dot_clock, lcd_signals.lcd_line_latch,
                         lcd_signals.lcd_panel_power, lcd_signals.lcd_video_bit0};

    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            sel_reg <= 32'h0000_0000;
        else if (commit_wr && avs_address == pfs_pkg::ADDR_SET)
            sel_reg <= sel_reg | hit_bits;
        else if (commit_wr && avs_address == pfs_pkg::ADDR_CLR)
            sel_reg <= sel_reg & ~hit_bits;

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    a_wait_new_req: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("new request answered without a wait cycle");
    a_state_mirror: assert property (avs_read && !avs_waitrequest && avs_address == pfs_pkg::ADDR_STATE
        |-> avs_readdata == sel_reg)
        else $error("state read differs from set and clear history");
    a_mapped_okay: assert property (commit_any && mapped |-> avs_response == pfs_pkg::RESP_OKAY)
        else $error("mapped access not answered okay");
    a_unmapped_err: assert property (commit_any && !mapped
        |-> avs_response == pfs_pkg::RESP_SLVERR && (avs_write || avs_readdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_pin2_source: assert property (!lcd_enable
        |=> pad_out.p2 == $past(sel_reg[2] ? timer1_match_out0 : gp_output_2))
        else $error("pin 2 source wrong");
    a_lcd_override: assert property (lcd_enable |=> pad_out == $past(lcd_pick))
        else $error("lcd does not own the pins");
    a_motor_gate: assert property (!lcd_enable && !timer_clock_control_reg[pfs_pkg::MC_CLK_BIT]
        |=> pad_out.p18 == $past(gp_output_18))
        else $error("pin 18 left gpo without motor clock");
    a_motor_route: assert property (!lcd_enable && timer_clock_control_reg[pfs_pkg::MC_CLK_BIT] && sel_reg[18]
        |=> pad_out.p18 == $past(motor_pwm.motor_pwm_ch0_out_a))
        else $error("pin 18 not on motor channel 0 a");
endmodule

bind pfs_port3_mux pfs_port3_mux_asserts u_asserts (.*);

// ---- dv/pfs_periph_model.sv ----
// pfs_periph_model: plain outputs and peripheral sources feeding the pin mux.
// assumes sources are synchronous to clk_sys.
`timescale 1ns/10ps
module pfs_periph_model
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    output      pfs_pkg::pfs_pins_t  gpo,
    output      pfs_pkg::pfs_motor_t motor_pwm,
    output      logic                timer1_match_out0,
    output      pfs_pkg::pfs_lcd_t   lcd_signals
);
    logic [21:0] pattern_reg;

    // sources change every cycle so a stale or swapped pick cannot match by luck
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            pattern_reg <= 22'h2A5F3C;
        else
            pattern_reg <= {pattern_reg[20:0], pattern_reg[21] ^ pattern_reg[20]} ^ 22'h0000_01;

    assign gpo               = pattern_reg[6:0];
    assign motor_pwm         = pattern_reg[12:7];
    assign timer1_match_out0 = pattern_reg[13];
    assign lcd_signals       = pattern_reg[21:14];
endmodule

// ---- dv/pfs_port3_mux_tb.sv ----
// pfs_port3_mux_tb: register access and pad source scenarios for the pin mux.
// assumes pfs_periph_model supplies all pin sources.
`timescale 1ns/10ps
module pfs_port3_mux_tb;
    logic                clk_sys;
    logic                rst_n;
    logic [31:0]         avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [31:0]         avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic [1:0]          avs_response;
    logic [31:0]         timer_clock_control_reg;
    logic                lcd_enable;
    logic                lcd_tft_mode;
    pfs_pkg::pfs_pins_t  gpo;
    pfs_pkg::pfs_motor_t motor_pwm;
    logic                timer1_match_out0;
    pfs_pkg::pfs_lcd_t   lcd_signals;
    pfs_pkg::pfs_pins_t  pad_out;
    logic [31:0]         rd;
    logic [31:0]         exp_sel;
    pfs_pkg::pfs_pins_t  exp_pad;
    int                  failures;
    int                  cmp_count;
    int                  pin_bits [7] = '{18, 16, 15, 13, 12, 10, 2};

    pfs_periph_model u_model (.clk_sys(clk_sys), .rst_n(rst_n), .gpo(gpo), .motor_pwm(motor_pwm),
        .timer1_match_out0(timer1_match_out0), .lcd_signals(lcd_signals));

    pfs_port3_mux DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .timer_clock_control_reg(timer_clock_control_reg), .lcd_enable(lcd_enable), .lcd_tft_mode(lcd_tft_mode),
        .gp_output_18(gpo.p18), .gp_output_16(gpo.p16), .gp_output_15(gpo.p15), .gp_output_13(gpo.p13),
        .gp_output_12(gpo.p12), .gp_output_10(gpo.p10), .gp_output_2(gpo.p2), .motor_pwm(motor_pwm),
        .timer1_match_out0(timer1_match_out0), .lcd_signals(lcd_signals), .pad_out(pad_out));

    always #2.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("mismatches %0d of %0d compares", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                       input logic [1:0] want_rs);
        int n;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            failures++;
            report_and_stop();
        end
        rd = avs_readdata;
        chk({30'h0, avs_response}, {30'h0, want_rs});
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, pfs_pkg::RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] want, input logic [1:0] want_rs);
        bus(1'b0, a, 32'h0000_0000, 4'hF, want_rs);
        chk(rd, want);
    endtask

    function automatic pfs_pkg::pfs_pins_t pick(input logic [31:0] s);
        logic m;
        m = timer_clock_control_reg[pfs_pkg::MC_CLK_BIT];
        if (lcd_enable)
            return {lcd_signals.lcd_line_pulse, lcd_tft_mode ? lcd_signals.lcd_data_enable : lcd_signals.lcd_ac_bias,
                    lcd_signals.lcd_frame_pulse, lcd_signals.lcd_dot_clock, lcd_signals.lcd_line_latch,
                    lcd_signals.lcd_panel_power, lcd_signals.lcd_video_bit0};
        return {s[18] && m ? motor_pwm.motor_pwm_ch0_out_a : gpo.p18,
                s[16] && m ? motor_pwm.motor_pwm_ch0_out_b : gpo.p16,
                s[15] && m ? motor_pwm.motor_pwm_ch1_out_a : gpo.p15,
                s[13] && m ? motor_pwm.motor_pwm_ch1_out_b : gpo.p13,
                s[12] && m ? motor_pwm.motor_pwm_ch2_out_a : gpo.p12,
                s[10] && m ? motor_pwm.motor_pwm_ch2_out_b : gpo.p10,
                s[2] ? timer1_match_out0 : gpo.p2};
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        avs_address = 32'h0000_0000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        timer_clock_control_reg = 32'h0000_0000;
        lcd_enable = 1'b0;
        lcd_tft_mode = 1'b0;
        failures = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk(pfs_pkg::ADDR_STATE, 32'h0000_0000, pfs_pkg::RESP_OKAY);
        exp_sel = 32'h0000_0000;
        foreach (pin_bits[i])
        begin
            wr(pfs_pkg::ADDR_SET, 32'h0000_0001 << pin_bits[i]);
            exp_sel |= 32'h0000_0001 << pin_bits[i];
            rd_chk(pfs_pkg::ADDR_STATE, exp_sel, pfs_pkg::RESP_OKAY);
        end
        wr(pfs_pkg::ADDR_SET, 32'h0000_0000);
        wr(pfs_pkg::ADDR_CLR, 32'h0000_0000);
        rd_chk(pfs_pkg::ADDR_STATE, pfs_pkg::SEL_MASK, pfs_pkg::RESP_OKAY);
        foreach (pin_bits[i])
        begin
            wr(pfs_pkg::ADDR_CLR, 32'h0000_0001 << pin_bits[i]);
            exp_sel &= ~(32'h0000_0001 << pin_bits[i]);
            rd_chk(pfs_pkg::ADDR_STATE, exp_sel, pfs_pkg::RESP_OKAY);
        end
        bus(1'b1, pfs_pkg::ADDR_SET, 32'hFFFF_FFFF, 4'h1, pfs_pkg::RESP_OKAY);
        wr(pfs_pkg::ADDR_STATE, pfs_pkg::SEL_MASK);
        rd_chk(pfs_pkg::ADDR_STATE, 32'h0000_0004, pfs_pkg::RESP_OKAY);
        rd_chk(pfs_pkg::ADDR_SET, 32'h0000_0000, pfs_pkg::RESP_OKAY);
        // reserved ones written above raise the sticky flag, a one written to it clears it
        rd_chk(pfs_pkg::ADDR_ROUTE, 32'h2000_0004, pfs_pkg::RESP_OKAY);
        wr(pfs_pkg::ADDR_ROUTE, 32'h2000_0000);
        rd_chk(pfs_pkg::ADDR_ROUTE, 32'h0000_0004, pfs_pkg::RESP_OKAY);
        bus(1'b1, pfs_pkg::ADDR_ROUTE + 32'h0000_0004, 32'h0000_0004, 4'hF, pfs_pkg::RESP_SLVERR);
        rd_chk(pfs_pkg::ADDR_ROUTE + 32'h0000_0004, 32'h0000_0000, pfs_pkg::RESP_SLVERR);
        // every mix of motor clock, lcd, panel mode and all-or-none selection, with sources moving
        for (int k = 0; k < 16; k++)
        begin
            timer_clock_control_reg <= {25'h0, k[0], 6'h00};
            lcd_enable <= k[1];
            lcd_tft_mode <= k[2];
            exp_sel = k[3] ? pfs_pkg::SEL_MASK : 32'h0000_0000;
            wr(k[3] ? pfs_pkg::ADDR_SET : pfs_pkg::ADDR_CLR, pfs_pkg::SEL_MASK);
            @(posedge clk_sys);
            exp_pad = pick(exp_sel);
            @(posedge clk_sys);
            chk({25'h0, pad_out}, {25'h0, exp_pad});
        end
        report_and_stop();
    end
endmodule
